// File: design/pic_pkg.sv
// Shared constants for the indicator control block
package pic_pkg;
    // ==========================================================
    // Register map (index words, byte address is index times 4)
    // ==========================================================
    localparam int PIC_AW = 12;
    localparam int PIC_DW = 32;
    localparam logic [9:0] PIC_IDX_CTRL = 10'h018;
    localparam logic [9:0] PIC_IDX_MODE = 10'h019;
    localparam logic [9:0] PIC_IDX_STAT = 10'h01a;
    localparam logic [11:0] PIC_ADDR_CTRL = {PIC_IDX_CTRL, 2'b00};
    localparam logic [11:0] PIC_ADDR_MODE = {PIC_IDX_MODE, 2'b00};
    localparam logic [11:0] PIC_ADDR_STAT = {PIC_IDX_STAT, 2'b00};

    // ==========================================================
    // Field positions
    // ==========================================================
    localparam int PIC_RATE_LO = 9;
    localparam int PIC_POL_LO = 6;
    localparam int PIC_FEN_LO = 3;
    localparam int PIC_FV_LO = 0;
    localparam int PIC_BYP_BIT = 7;
    localparam int PIC_MODE_LO = 5;

    // ==========================================================
    // Reset values and writable masks
    // ==========================================================
    localparam logic [15:0] PIC_CTRL_RST = 16'h05c0;
    localparam logic [15:0] PIC_CTRL_WMASK = 16'h07ff;
    localparam logic [15:0] PIC_MODE_RST = 16'h0000;
    localparam logic [15:0] PIC_MODE_WMASK = 16'h00e0;

    // ==========================================================
    // Timing
    // ==========================================================
    localparam int unsigned PIC_CLK_MHZ = 200;
    localparam int unsigned PIC_CYC_PER_MS = PIC_CLK_MHZ * 1000;
    localparam int unsigned PIC_BLINK_MS_0 = 50;
    localparam int unsigned PIC_BLINK_MS_1 = 100;
    localparam int unsigned PIC_BLINK_MS_2 = 200;
    localparam int unsigned PIC_BLINK_MS_3 = 500;
    localparam int PIC_CNT_W = 27;
    localparam logic [1:0] PIC_STRAP_SYNC = 2'h2;
endpackage : pic_pkg

// File: design/pic_blink_timer.sv
// Blink period timer producing one tick per on or off phase
`timescale 1ns/1ps
module pic_blink_timer #(
    parameter int unsigned cycles_per_ms = pic_pkg::PIC_CYC_PER_MS
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [1:0] rate,
    output logic tick
);
    import pic_pkg::*;

    typedef struct packed {
        logic [PIC_CNT_W-1:0] cnt;
        logic tick;
    } pic_tmr_s;

    pic_tmr_s r;
    pic_tmr_s next_r;
    logic [PIC_CNT_W-1:0] limit;

    // ==========================================================
    // Period select
    // ==========================================================
    // Last cycle of the selected phase length
    always_comb begin
        unique case (rate)
            2'h0: limit = PIC_CNT_W'(PIC_BLINK_MS_0 * cycles_per_ms - 1);
            2'h1: limit = PIC_CNT_W'(PIC_BLINK_MS_1 * cycles_per_ms - 1);
            2'h2: limit = PIC_CNT_W'(PIC_BLINK_MS_2 * cycles_per_ms - 1);
            2'h3: limit = PIC_CNT_W'(PIC_BLINK_MS_3 * cycles_per_ms - 1);
        endcase
    end

    // ==========================================================
    // Counter
    // ==========================================================
    // Compare with >= so a shorter rate never overruns the wrap
    always_comb begin
        next_r = r;
        if (r.cnt >= limit) begin
            next_r.cnt = '0;
            next_r.tick = 1'b1;
        end else begin
            next_r.cnt = r.cnt + 1'b1;
            next_r.tick = 1'b0;
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign tick = r.tick;

    // ==========================================================
    // Checks
    // ==========================================================
    property p_tick_at_limit;
        @(posedge pclk) disable iff (!presetn)
        tick |-> ($past(r.cnt) >= $past(limit)) && (r.cnt == '0);
    endproperty
    a_tick_at_limit: assert property (p_tick_at_limit)
        else $error("Blink tick not at period end");

    property p_tick_gap;
        @(posedge pclk) disable iff (!presetn)
        (tick && limit > 0) |=> !tick;
    endproperty
    a_tick_gap: assert property (p_tick_gap)
        else $error("Blink ticks back to back");
endmodule : pic_blink_timer

// File: design/pic_indicator.sv
// Indicator lamp control: polarity, forcing, blinking, APB registers
`timescale 1ns/1ps
module pic_indicator #(
    parameter int unsigned cycles_per_ms = pic_pkg::PIC_CYC_PER_MS
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [pic_pkg::PIC_AW-1:0] paddr,
    input wire logic [pic_pkg::PIC_DW-1:0] pwdata,
    output logic [pic_pkg::PIC_DW-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic link_good,
    input wire logic speed_100,
    input wire logic activity,
    input wire logic collision,
    input wire logic speed_pol_strap,
    input wire logic link_pol_strap,
    input wire logic act_pol_strap,
    output logic speed_indicator_out,
    output logic link_indicator_out,
    output logic activity_indicator_out
);
    import pic_pkg::*;

    typedef struct packed {
        logic [15:0] ctl;
        logic [15:0] mode_reg;
        logic [2:0] strap_s1;
        logic [2:0] strap_s2;
        logic [1:0] strap_cnt;
        logic strap_done;
        logic act_pend;
        logic act_shown;
        logic [PIC_DW-1:0] prdata;
        logic pready;
        logic pslverr;
        logic [2:0] outs;
    } pic_state_s;

    pic_state_s r;
    pic_state_s next_r;
    logic tick;
    logic setup;
    logic access;
    logic wr_ctl;
    logic wr_mode;
    logic mode_one;
    logic bypass;
    logic act_raw;
    logic [2:0] norm;
    logic [2:0] pol;
    logic [2:0] fen;
    logic [2:0] fv;
    logic [2:0] sel;

    // ==========================================================
    // Blink timer
    // ==========================================================
    pic_blink_timer #(
        .cycles_per_ms(cycles_per_ms)
    ) u_timer (
        .pclk(pclk),
        .presetn(presetn),
        .rate(r.ctl[PIC_RATE_LO+:2]),
        .tick(tick)
    );

    // ==========================================================
    // Decode and status selection
    // ==========================================================
    // Bus phases and register field views
    always_comb begin
        setup = psel && !penable;
        access = psel && penable && r.pready;
        wr_ctl = access && pwrite && (paddr == PIC_ADDR_CTRL);
        wr_mode = access && pwrite && (paddr == PIC_ADDR_MODE);
        mode_one = r.mode_reg[PIC_MODE_LO];
        bypass = r.mode_reg[PIC_BYP_BIT];
        pol = r.ctl[PIC_POL_LO+:3];
        fen = r.ctl[PIC_FEN_LO+:3];
        fv = r.ctl[PIC_FV_LO+:3];
        // Mode two also covers the undefined code 10
        act_raw = mode_one ? activity : collision;
        norm[2] = speed_100;
        norm[1] = link_good;
        norm[0] = bypass ? act_raw : r.act_shown;
        // Force first, then polarity on the chosen value
        sel = (fen & fv) | (~fen & norm);
    end

    // ==========================================================
    // Next state
    // ==========================================================
    // Strap capture, register writes, stretch, bus answer, lamps
    always_comb begin
        next_r = r;
        next_r.strap_s1 = {speed_pol_strap, link_pol_strap, act_pol_strap};
        next_r.strap_s2 = r.strap_s1;
        // Capture waits for the synchroniser to fill after release
        if (!r.strap_done) begin
            if (r.strap_cnt == PIC_STRAP_SYNC) begin
                next_r.ctl[PIC_POL_LO+:3] = r.strap_s2;
                next_r.strap_done = 1'b1;
            end else begin
                next_r.strap_cnt = r.strap_cnt + 1'b1;
            end
        end
        // A write beats the strap and ends the capture window
        if (wr_ctl) begin
            next_r.ctl = pwdata[15:0] & PIC_CTRL_WMASK;
            next_r.strap_done = 1'b1;
        end
        if (wr_mode) begin
            next_r.mode_reg = pwdata[15:0] & PIC_MODE_WMASK;
        end
        // Activity stretch: events while the lamp is dark are held and light it at the next tick
        if (tick) begin
            next_r.act_pend = act_raw;
            next_r.act_shown = (r.act_pend || act_raw) && !r.act_shown;
        end else begin
            next_r.act_pend = r.act_pend || act_raw;
        end
        // Ready registered from setup: no wait state, read data come from a flip-flop
        next_r.pready = setup;
        next_r.pslverr = 1'b0;
        next_r.prdata = '0;
        if (setup) begin
            unique case (paddr)
                PIC_ADDR_CTRL: next_r.prdata = {16'h0000, r.ctl};
                PIC_ADDR_MODE: next_r.prdata = {16'h0000, r.mode_reg};
                PIC_ADDR_STAT: begin
                    next_r.prdata = {28'h000_0000, r.strap_done, r.outs};
                end
                default: next_r.pslverr = 1'b1;
            endcase
        end
        next_r.outs = sel ~^ pol;
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
            r.ctl <= PIC_CTRL_RST;
            r.mode_reg <= PIC_MODE_RST;
        end else begin
            r <= next_r;
        end
    end

    // Outputs straight from the state register
    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;
    assign speed_indicator_out = r.outs[2];
    assign link_indicator_out = r.outs[1];
    assign activity_indicator_out = r.outs[0];

    // ==========================================================
    // Checks
    // ==========================================================
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_rate_write;
        wr_ctl |=> r.ctl[PIC_RATE_LO+:2] == $past(pwdata[PIC_RATE_LO+:2]);
    endproperty
    a_rate_write: assert property (p_rate_write)
        else $error("Blink rate not stored");

    sequence s_capture;
        !r.strap_done && (r.strap_cnt == PIC_STRAP_SYNC) && !wr_ctl;
    endsequence
    property p_strap;
        s_capture |=> (r.ctl[PIC_POL_LO+:3] == $past(r.strap_s2))
            && r.strap_done;
    endproperty
    a_strap: assert property (p_strap)
        else $error("Strap polarity not captured");

    property p_spd_out;
        1'b1 |=> speed_indicator_out ==
            (($past(fen[2]) ? $past(fv[2]) : $past(norm[2]))
            ~^ $past(pol[2]));
    endproperty
    a_spd_out: assert property (p_spd_out)
        else $error("Speed lamp value wrong");

    property p_lnk_out;
        1'b1 |=> link_indicator_out ==
            (($past(fen[1]) ? $past(fv[1]) : $past(link_good))
            ~^ $past(pol[1]));
    endproperty
    a_lnk_out: assert property (p_lnk_out)
        else $error("Link lamp value wrong");

    property p_act_out;
        1'b1 |=> activity_indicator_out ==
            (($past(fen[0]) ? $past(fv[0]) : $past(norm[0]))
            ~^ $past(pol[0]));
    endproperty
    a_act_out: assert property (p_act_out)
        else $error("Activity lamp value wrong");

    // Speed forced alone: link lamp still follows link status
    property p_force_indep;
        (fen == 3'h4) |=>
            link_indicator_out == ($past(link_good) ~^ $past(pol[1]));
    endproperty
    a_force_indep: assert property (p_force_indep)
        else $error("Speed force leaked onto link");

    property p_resv_zero;
        pready && !pslverr |-> prdata[31:11] == '0;
    endproperty
    a_resv_zero: assert property (p_resv_zero)
        else $error("Reserved bits read non-zero");

    // Checked at the pins so a broken source select shows up
    property p_mode_two;
        !mode_one && bypass && (fen == 3'h0) |=>
            {speed_indicator_out, link_indicator_out, activity_indicator_out}
            == ($past({speed_100, link_good, collision}) ~^ $past(pol));
    endproperty
    a_mode_two: assert property (p_mode_two)
        else $error("Mode two sources wrong");

    property p_mode_one;
        mode_one && bypass && !fen[0] |=>
            activity_indicator_out == ($past(activity) ~^ $past(pol[0]));
    endproperty
    a_mode_one: assert property (p_mode_one)
        else $error("Mode one activity source wrong");

    property p_stretch_off;
        !bypass && tick && !r.act_pend && !act_raw |=> !r.act_shown;
    endproperty
    a_stretch_off: assert property (p_stretch_off)
        else $error("Idle activity stayed lit");
endmodule : pic_indicator

// File: bench/pic_lamp_board.sv
// Board lamp model: lit state and activity blink period meter
`timescale 1ns/1ps
module pic_lamp_board (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [2:0] pins,
    input wire logic [2:0] pol,
    output logic [2:0] lit,
    output int act_period
);
    logic prev;
    int cnt;
    // ==========================================================
    // Lamp model
    // ==========================================================
    // A lamp lights when its pin level matches the board wiring
    assign lit = ~(pins ^ pol);
    // Cycles between two changes of the activity lamp
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev <= 1'b0;
            cnt <= 0;
            act_period <= 0;
        end else begin
            prev <= lit[0];
            if (lit[0] != prev) begin
                act_period <= cnt;
                cnt <= 1;
            end else begin
                cnt <= cnt + 1;
            end
        end
    end
endmodule : pic_lamp_board

// File: bench/test_phy_indicator_control.sv
// Self-checking bench for the indicator control block
`timescale 1ns/1ps
module test_phy_indicator_control;
    import pic_pkg::*;
    // Small ms scale keeps the 500 ms phase at 1000 cycles
    localparam int unsigned CPM = 2;
    logic pclk = 0;
    logic presetn = 0;
    logic psel = 0;
    logic penable = 0;
    logic pwrite = 0;
    logic [PIC_AW-1:0] paddr = '0;
    logic [PIC_DW-1:0] pwdata = '0;
    logic [PIC_DW-1:0] prdata;
    logic pready;
    logic pslverr;
    logic link_good = 1;
    logic speed_100 = 0;
    logic activity = 0;
    logic collision = 0;
    logic [2:0] strap = 3'b101;
    logic [2:0] pins;
    logic [2:0] lit;
    logic [31:0] rd;
    logic err;
    logic [2:0] f;
    logic [2:0] p;
    int act_period;
    int n_fail = 0;
    int total_checks = 0;
    int ms[4] = '{50, 100, 200, 500};

    // ==========================================================
    // Design and board
    // ==========================================================
    pic_indicator #(.cycles_per_ms(CPM)) i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link_good(link_good),
        .speed_100(speed_100), .activity(activity),
        .collision(collision), .speed_pol_strap(strap[2]),
        .link_pol_strap(strap[1]), .act_pol_strap(strap[0]),
        .speed_indicator_out(pins[2]), .link_indicator_out(pins[1]),
        .activity_indicator_out(pins[0])
    );
    pic_lamp_board u_board (
        .pclk(pclk), .presetn(presetn), .pins(pins),
        .pol(3'b111), .lit(lit), .act_period(act_period)
    );
    // Free running 200 MHz clock
    always #2.5 pclk = ~pclk;

    // ==========================================================
    // Tasks
    // ==========================================================
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input string nm, input logic [31:0] s,
                       input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask : chk

    // One APB transfer; result left in rd and err
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            n_fail++;
            stop_test();
        end else begin
            rd = prdata;
            err = pslverr;
            psel <= 0;
            penable <= 0;
        end
    endtask : apb

    // Activity lamp check for one mode and status pair
    task automatic act_case(input logic [31:0] m, input logic a,
                            input logic c, input logic e);
        apb(1, PIC_ADDR_MODE, m);
        activity <= a;
        collision <= c;
        repeat (3) @(posedge pclk);
        chk("activity lamp", {31'h0, pins[0]}, {31'h0, e});
    endtask : act_case

    // ==========================================================
    // Main sequence
    // ==========================================================
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1;
        repeat (5) @(posedge pclk);
        apb(0, PIC_ADDR_CTRL, 0);
        chk("ctrl reset", rd, 32'h0000_0540);
        chk("lamps reset", {29'h0, pins}, 32'h0000_0000);
        apb(0, PIC_ADDR_STAT, 0);
        chk("status reset", rd, 32'h0000_0008);
        apb(1, PIC_ADDR_CTRL, 32'hffff_ffff);
        apb(0, PIC_ADDR_CTRL, 0);
        chk("ctrl reserved", rd, 32'h0000_07ff);
        apb(1, PIC_ADDR_MODE, 32'hffff_ffff);
        apb(0, PIC_ADDR_MODE, 0);
        chk("mode reg", rd, 32'h0000_00e0);
        apb(0, 12'h000, 0);
        chk("unmapped error", {31'h0, err}, 32'h0000_0001);
        // Every force subset, with polarity varied alongside
        apb(1, PIC_ADDR_MODE, 32'h0000_00a0);
        for (int i = 0; i < 8; i++) begin
            f = i[2:0];
            p = f ^ 3'b101;
            apb(1, PIC_ADDR_CTRL, {21'h0, 2'b10, p, f, 3'b011});
            repeat (3) @(posedge pclk);
            chk("lamps", {29'h0, pins},
                {29'h0, ((f & 3'b011) | (~f & 3'b010)) ~^ p});
        end
        apb(1, PIC_ADDR_CTRL, 32'h0000_05c0);
        speed_100 <= 1;
        act_case(32'h0000_0080, 0, 1, 1);
        chk("speed lamp", {31'h0, pins[2]}, 32'h0000_0001);
        act_case(32'h0000_00a0, 0, 1, 0);
        act_case(32'h0000_00a0, 1, 0, 1);
        // Stretching on, no traffic: dark after two ticks at most
        apb(1, PIC_ADDR_MODE, 32'h0000_0020);
        activity <= 0;
        collision <= 0;
        repeat (3 * PIC_BLINK_MS_2 * CPM) @(posedge pclk);
        chk("idle activity", {31'h0, pins[0]}, 32'h0000_0000);
        // Continuous activity blinks at the selected phase length
        activity <= 1;
        for (int r = 0; r < 4; r++) begin
            apb(1, PIC_ADDR_CTRL, {21'h0, r[1:0], 9'h1c0});
            repeat (3 * ms[r] * CPM) @(posedge pclk);
            chk("blink period", act_period, ms[r] * CPM);
        end
        stop_test();
    end
endmodule : test_phy_indicator_control
